// file: rtl/pmhc_channel.sv
// Power-management host channel: two mailbox channels, host and controller side
`timescale 1ns/1ps
`default_nettype none
module pmhc_channel
  import pmhc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Host side, one select per channel
  input  wire logic [1:0]  hostSel,
  input  wire logic        hostAddr2,
  input  wire logic        hostWr,
  input  wire logic        hostRd,
  input  wire logic [7:0]  hostWdata,
  output logic      [7:0]  hostRdata,
  output logic             hostReady,
  // Internal processor side
  input  wire logic [15:0] ecAddr,
  input  wire logic        ecWr,
  input  wire logic        ecRd,
  input  wire logic [7:0]  ecWdata,
  output logic      [7:0]  ecRdata,
  // Host interrupt lines per channel
  output logic      [1:0]  sciOut,
  output logic      [1:0]  smiOut
);
  logic [7:0] hostRdataCh [2];
  logic [7:0] ecRdataCh   [2];
  logic [1:0] hostReadyCh, ecHit;
  logic [7:0] next_hostRdata, next_ecRdata;
  logic       next_hostReady;

  for (genvar c = 0; c < 2; c++) begin : g_ch // R18
    localparam logic [15:0] BASE = (c == 0) ? PMHC_BASE_CH1 : PMHC_BASE_CH2;
    logic [7:0] outBuf, next_outBuf, inBuf, next_inBuf;
    logic [7:0] ctlReg, icReg, ieReg, next_ctlReg, next_icReg, next_ieReg;
    logic [3:0] userFlags, next_userFlags;
    logic       spare, next_spare, cmdInd, next_cmdInd;
    logic       input_buffer_full, next_ibf, output_buffer_full, next_obf;
    logic       sci, smi, next_sci, next_smi;
    logic       sel, hWr, hRd, eWr, eRd;
    logic [3:0] ofs;
    logic       fInReady, fOutValid, popReq;
    logic [8:0] fOut;
    logic [7:0] stat, next_ecRd;

    assign sel = (ecAddr[15:4] == BASE[15:4]); // R8
    assign ofs = ecAddr[3:0];
    assign eWr = ecWr && sel;
    assign eRd = ecRd && sel;
    // Host write refused while FIFO full; host sees hostReady low
    assign hWr = hostWr && hostSel[c] && fInReady;
    assign hRd = hostRd && hostSel[c];
    assign stat = {userFlags, cmdInd, spare, input_buffer_full, output_buffer_full};

    // Host bytes queue here; one byte at a time sits in the input buffer
    pmhc_fifo #(.WIDTH(9), .DEPTH(PMHC_FIFO_DEPTH)) u_fifo (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .inValid  (hostWr && hostSel[c]),
      .inReady  (fInReady),
      .inData   ({hostAddr2, hostWdata}),
      .outValid (fOutValid),
      .outReady (popReq),
      .outData  (fOut)
    );
    // Load next byte once the buffer is drained by the processor
    assign popReq = fOutValid && (!input_buffer_full || (eRd && (ofs == PMHC_OFS_DI || ofs == PMHC_OFS_DI_SCI)));

    always_comb begin
      next_outBuf = outBuf;
      next_inBuf = inBuf;
      next_ctlReg = ctlReg;
      next_icReg = icReg;
      next_ieReg = ieReg;
      next_userFlags = userFlags;
      next_spare = spare;
      next_cmdInd = cmdInd;
      next_ibf = input_buffer_full;
      next_obf = output_buffer_full;
      next_sci = 1'b0;
      next_smi = 1'b0;
      next_ecRd = 8'h00;
      // Host read of data port clears output-full
      if (hRd && !hostAddr2) begin
        next_obf = 1'b0; // R7
      end
      // Host status-port writes leave the user and spare flags alone; only the processor sets them
      if (eWr) begin
        case (ofs)
          PMHC_OFS_STS: begin
            next_userFlags = ecWdata[7:PMHC_ST_UFL]; // R3
            next_spare = ecWdata[PMHC_ST_GPF]; // R5
          end
          PMHC_OFS_DO, PMHC_OFS_DO_SCI, PMHC_OFS_DO_SMI: begin
            next_outBuf = ecWdata; // R9 R10
            next_obf = 1'b1; // R7
            next_sci = (ofs == PMHC_OFS_DO_SCI) && ieReg[PMHC_IE_SCI]; // R14
            next_smi = (ofs == PMHC_OFS_DO_SMI) && ieReg[PMHC_IE_SMI]; // R15
          end
          PMHC_OFS_CTL: next_ctlReg = ecWdata; // R12
          PMHC_OFS_IC: next_icReg = ecWdata;
          PMHC_OFS_IE: next_ieReg = ecWdata;
          default: ;
        endcase
      end
      if (eRd) begin
        case (ofs)
          PMHC_OFS_STS: next_ecRd = stat; // R17
          PMHC_OFS_DI, PMHC_OFS_DI_SCI: begin
            next_ecRd = inBuf; // R11
            next_ibf = 1'b0; // R6
            next_sci = (ofs == PMHC_OFS_DI_SCI) && ieReg[PMHC_IE_SCI]; // R16
          end
          PMHC_OFS_CTL: next_ecRd = ctlReg;
          PMHC_OFS_IC: next_ecRd = icReg;
          PMHC_OFS_IE: next_ecRd = ieReg;
          default: next_ecRd = 8'h00;
        endcase
      end
      // A loaded byte sets full; this wins over a same-cycle clear
      if (popReq) begin
        next_inBuf = fOut[7:0]; // R13
        next_cmdInd = fOut[8]; // R2 R4
        next_ibf = 1'b1; // R6
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        outBuf <= PMHC_RST_BYTE;
        inBuf <= PMHC_RST_BYTE;
        ctlReg <= PMHC_RST_BYTE;
        icReg <= PMHC_RST_BYTE;
        ieReg <= PMHC_RST_BYTE;
        userFlags <= 4'h0;
        spare <= 1'b0;
        cmdInd <= 1'b0;
        input_buffer_full <= 1'b0;
        output_buffer_full <= 1'b0;
        sci <= 1'b0;
        smi <= 1'b0;
      end else begin
        outBuf <= next_outBuf;
        inBuf <= next_inBuf;
        ctlReg <= next_ctlReg;
        icReg <= next_icReg;
        ieReg <= next_ieReg;
        userFlags <= next_userFlags;
        spare <= next_spare;
        cmdInd <= next_cmdInd;
        input_buffer_full <= next_ibf;
        output_buffer_full <= next_obf;
        sci <= next_sci;
        smi <= next_smi;
      end
    end

    // Host read data: data port gives output buffer, status port gives flags
    assign hostRdataCh[c] = hostAddr2 ? stat : outBuf; // R1 R17
    assign hostReadyCh[c] = fInReady;
    assign ecRdataCh[c] = next_ecRd;
    assign ecHit[c] = eRd;
    assign sciOut[c] = sci;
    assign smiOut[c] = smi;
  end

  // Registered read muxes so every port comes from a flop
  always_comb begin
    next_hostRdata = 8'h00;
    next_hostReady = |(hostSel & hostReadyCh) || (hostSel == 2'b00);
    next_ecRdata = 8'h00;
    if (hostSel[0]) begin
      next_hostRdata = hostRdataCh[0];
    end else if (hostSel[1]) begin
      next_hostRdata = hostRdataCh[1];
    end
    if (ecHit[0]) begin
      next_ecRdata = ecRdataCh[0];
    end else if (ecHit[1]) begin
      next_ecRdata = ecRdataCh[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hostRdata <= 8'h00;
      hostReady <= 1'b1;
      ecRdata <= 8'h00;
    end else begin
      hostRdata <= next_hostRdata;
      hostReady <= next_hostReady;
      ecRdata <= next_ecRdata;
    end
  end
endmodule : pmhc_channel
`default_nettype wire

// file: rtl/pmhc_pkg.sv
// Package for the power-management host channel: offsets, fields, reset values
// Functional notes
// [R1] Host data read returns the byte last written to the output buffer
// [R2] Host command write at second base is recorded with indicator set to one
// [R3] Status bits 7..4 are read/write general-purpose flags
// [R4] Status bit 3 holds address bit two of the last host write; code takes it from the byte loaded into the input buffer
// [R5] Status bit 2 is a plain read/write spare flag, no side effects
// [R6] Input-full flag set by host writes, cleared by controller input reads
// [R7] Output-full flag set by controller output writes, cleared by host data read
// [R8] Controller registers at internal base 1500h and 1510h, processor only
// [R9] Status mirror at offset 00h, plain output write at 01h
// [R10] Output write aliases at 02h with SCI and 03h with SMI
// [R11] Input buffer readable at 04h and SCI alias at 05h
// [R12] Control 06h, interrupt control 07h, interrupt enable 08h
// [R13] Host data or command writes store into one shared input buffer
// [R14] Controller write to SCI output alias raises SCI when enabled
// [R15] Controller write to SMI output alias raises SMI when enabled
// [R16] Controller read of SCI input alias raises SCI when enabled
// [R17] Status reads from either side have no side effects
// [R18] Two independent channel instances with own buffers, flags and bases
package pmhc_pkg;
  localparam logic [15:0] PMHC_BASE_CH1   = 16'h1500;
  localparam logic [15:0] PMHC_BASE_CH2   = 16'h1510;
  localparam logic [3:0]  PMHC_OFS_STS    = 4'h0;
  localparam logic [3:0]  PMHC_OFS_DO     = 4'h1;
  localparam logic [3:0]  PMHC_OFS_DO_SCI = 4'h2;
  localparam logic [3:0]  PMHC_OFS_DO_SMI = 4'h3;
  localparam logic [3:0]  PMHC_OFS_DI     = 4'h4;
  localparam logic [3:0]  PMHC_OFS_DI_SCI = 4'h5;
  localparam logic [3:0]  PMHC_OFS_CTL    = 4'h6;
  localparam logic [3:0]  PMHC_OFS_IC     = 4'h7;
  localparam logic [3:0]  PMHC_OFS_IE     = 4'h8;
  // Status field positions
  localparam int PMHC_ST_OBF = 0;
  localparam int PMHC_ST_IBF = 1;
  localparam int PMHC_ST_GPF = 2;
  localparam int PMHC_ST_CMD = 3;
  localparam int PMHC_ST_UFL = 4;
  // Enable bits chosen inside interrupt enable register
  localparam int PMHC_IE_SMI = 1;
  localparam int PMHC_IE_SCI = 2;
  localparam logic [7:0] PMHC_RST_BYTE = 8'h00;
  localparam int PMHC_FIFO_DEPTH = 32;
endpackage : pmhc_pkg

// file: rtl/pmhc_fifo.sv
// Parameterised valid/ready FIFO carrying host-written bytes
`timescale 1ns/1ps
`default_nettype none
module pmhc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // Honest full/empty from occupancy
  assign inReady  = (count != AW'(0) || 1'b1) && (count < (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    next_wrPtr = push ? wrPtr + AW'(1) : wrPtr;
    next_rdPtr = pop ? rdPtr + AW'(1) : rdPtr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage array has no reset; pointers do
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end
endmodule : pmhc_fifo
`default_nettype wire

// file: testbench/pmhc_props.sv
// Port checker for the power-management host channel
`timescale 1ns/1ps
`default_nettype none
module pmhc_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  hostSel,
  input wire logic        hostAddr2,
  input wire logic        hostRd,
  input wire logic [7:0]  hostRdata,
  input wire logic        hostReady,
  input wire logic [15:0] ecAddr,
  input wire logic        ecWr,
  input wire logic        ecRd,
  input wire logic [7:0]  ecWdata,
  input wire logic [7:0]  ecRdata,
  input wire logic [1:0]  sciOut,
  input wire logic [1:0]  smiOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Every interrupt pulse needs its own processor access one cycle before
  property p_sci1; sciOut[0] |-> $past(ecWr && ecAddr == 16'h1502 || ecRd && ecAddr == 16'h1505);
  endproperty
  property p_smi1; smiOut[0] |-> $past(ecWr && ecAddr == 16'h1503); endproperty
  property p_sci2; sciOut[1] |-> $past(ecWr && ecAddr == 16'h1512 || ecRd && ecAddr == 16'h1515);
  endproperty
  property p_smi2; smiOut[1] |-> $past(ecWr && ecAddr == 16'h1513); endproperty
  property p_plain; ecWr && ecAddr == 16'h1501 |=> sciOut == 2'b00 && smiOut == 2'b00; endproperty
  property p_unmap; ecRd && ecAddr == 16'h1509 |=> ecRdata == 8'h00; endproperty
  // Host read right behind a processor write sees that byte
  property p_hdata; ecWr && ecAddr == 16'h1501 ##1 hostRd && hostSel == 2'b01 && !hostAddr2
    |=> hostRdata == $past(ecWdata, 2); endproperty
  property p_obfclr; hostRd && hostSel == 2'b01 && !hostAddr2 && !ecWr ##1
    ecRd && ecAddr == 16'h1500 && !ecWr |=> !ecRdata[0]; endproperty
  a_sci1: assert property (p_sci1) else $error("stray sci on channel one");
  a_smi1: assert property (p_smi1) else $error("stray smi on channel one");
  a_sci2: assert property (p_sci2) else $error("stray sci on channel two");
  a_smi2: assert property (p_smi2) else $error("stray smi on channel two");
  a_plain: assert property (p_plain) else $error("plain write raised interrupt");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_hdata: assert property (p_hdata) else $error("host data differs");
  a_obfclr: assert property (p_obfclr) else $error("output full not cleared");
  c_sci: cover property (sciOut[0]);
  c_smi: cover property (smiOut[1]);
  c_full: cover property (!hostReady);
endmodule : pmhc_props
`default_nettype wire

// file: testbench/pmhc_host_model.sv
// Host processor model issuing data, command and status cycles
`timescale 1ns/1ps
`default_nettype none
module pmhc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] hostRdata,
  output logic      [1:0] hostSel,
  output logic            hostAddr2,
  output logic            hostWr,
  output logic            hostRd,
  output logic      [7:0] hostWdata
);
  // Idle bus at time zero
  initial begin
    hostSel = 2'b00;
    hostAddr2 = 1'b0;
    hostWr = 1'b0;
    hostRd = 1'b0;
    hostWdata = 8'h00;
  end
  // Strobe left high so writes can run back to back
  task automatic wr(input logic [1:0] ch, input logic a2, input logic [7:0] d);
    @(negedge core_clk);
    hostSel <= ch;
    hostAddr2 <= a2;
    hostWr <= 1'b1;
    hostWdata <= d;
  endtask : wr
  // Released data flips so a stale byte never looks valid
  task automatic idle;
    @(negedge core_clk);
    hostSel <= 2'b00;
    hostWr <= 1'b0;
    hostWdata <= ~hostWdata;
  endtask : idle
  // Read data is registered on the edge that takes the strobe and sampled at the next falling edge
  task automatic rd(input logic [1:0] ch, input logic a2, output logic [7:0] d);
    @(negedge core_clk);
    hostSel <= ch;
    hostAddr2 <= a2;
    hostRd <= 1'b1;
    @(negedge core_clk);
    d = hostRdata;
    hostRd <= 1'b0;
    hostSel <= 2'b00;
  endtask : rd
endmodule : pmhc_host_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the power-management host channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk, rst_n, hostAddr2, hostWr, hostRd, hostReady, ecWr, ecRd;
  logic [1:0]  hostSel, sciOut, smiOut;
  logic [7:0]  hostWdata, hostRdata, ecWdata, ecRdata, d;
  logic [15:0] ecAddr;
  int          mismatches, nCompared, cycles, refused;
  pmhc_channel uut (.core_clk, .rst_n, .hostSel, .hostAddr2, .hostWr, .hostRd, .hostWdata,
    .hostRdata, .hostReady, .ecAddr, .ecWr, .ecRd, .ecWdata, .ecRdata, .sciOut, .smiOut);
  pmhc_host_model hm (.core_clk, .hostRdata, .hostSel, .hostAddr2, .hostWr, .hostRd, .hostWdata);
  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ecw(input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    ecAddr <= a;
    ecWr <= 1'b1;
    ecWdata <= v;
    @(negedge core_clk);
    ecWr <= 1'b0;
    ecWdata <= ~v;
  endtask : ecw
  task automatic ecr(input logic [15:0] a, output logic [7:0] v);
    @(negedge core_clk);
    ecAddr <= a;
    ecRd <= 1'b1;
    @(negedge core_clk);
    v = ecRdata;
    ecRd <= 1'b0;
  endtask : ecr
  task automatic t_regs;
    check({7'h00, hostReady}, 8'h01);
    ecr(16'h1500, d); check(d, 8'h00);
    for (int a = 6; a < 9; a++) begin
      ecw(16'h1500 + a, 8'h06);
      ecr(16'h1500 + a, d); check(d, 8'h06);
      ecw(16'h1510 + a, 8'h06);
    end
    ecr(16'h1509, d); check(d, 8'h00);
  endtask : t_regs
  task automatic t_out;
    for (int k = 1; k < 4; k++) begin
      ecw(16'h1500 + k, 8'hA0 + k);
      check({6'h00, sciOut[0], smiOut[0]}, (k == 2) ? 8'h02 : (k == 3) ? 8'h01 : 8'h00);
      hm.rd(2'b01, 1'b0, d); check(d, 8'hA0 + k);
      ecr(16'h1500, d); check(d & 8'h01, 8'h00);
    end
  endtask : t_out
  task automatic t_in;
    hm.wr(2'b01, 1'b0, 8'h5A);
    hm.idle;
    repeat (4) @(negedge core_clk);
    ecr(16'h1500, d); check(d & 8'h0A, 8'h02);
    ecr(16'h1504, d); check(d, 8'h5A);
    ecr(16'h1500, d); check(d & 8'h02, 8'h00);
    hm.wr(2'b01, 1'b1, 8'hC3);
    hm.idle;
    repeat (4) @(negedge core_clk);
    ecr(16'h1500, d); check(d & 8'h0A, 8'h0A);
    ecr(16'h1505, d); check(d, 8'hC3);
    check({7'h00, sciOut[0]}, 8'h01);
  endtask : t_in
  task automatic t_flags;
    ecw(16'h1500, 8'hF4);
    hm.rd(2'b01, 1'b1, d); check(d & 8'hF4, 8'hF4);
    hm.rd(2'b01, 1'b1, d); check(d & 8'hF6, 8'hF4);
  endtask : t_flags
  task automatic t_ch2;
    ecw(16'h1513, 8'h77);
    check({6'h00, smiOut}, 8'h02);
    hm.rd(2'b10, 1'b1, d); check(d & 8'h01, 8'h01);
    hm.rd(2'b10, 1'b0, d); check(d, 8'h77);
    hm.rd(2'b01, 1'b1, d); check(d & 8'h01, 8'h00);
  endtask : t_ch2
  // Host read right behind a processor write, then a status read right behind that
  task automatic t_b2b;
    logic [7:0] hd, sd;
    fork
      ecw(16'h1501, 8'h3C);
      begin
        @(negedge core_clk);
        hm.rd(2'b01, 1'b0, hd);
      end
      begin
        repeat (2) @(negedge core_clk);
        ecr(16'h1500, sd);
      end
    join
    check(hd, 8'h3C);
    check(sd & 8'h01, 8'h00);
  endtask : t_b2b
  // Controller stalls while the host overfills the queue
  task automatic t_fifo;
    for (int i = 0; i < 40; i++) begin
      hm.wr(2'b01, 1'b0, i[7:0]);
      if (hostReady !== 1'b1) refused++;
    end
    hm.idle;
    check({7'h00, refused > 0}, 8'h01);
    for (int i = 0; i < 33; i++) begin
      repeat (4) @(negedge core_clk);
      ecr(16'h1504, d); check(d, i[7:0]);
    end
    repeat (4) @(negedge core_clk);
    ecr(16'h1500, d); check(d & 8'h02, 8'h00);
  endtask : t_fifo
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // Reset for 20 cycles, then the scenarios
  initial begin
    {mismatches, nCompared, cycles, refused} = '0;
    {rst_n, ecWr, ecRd, ecAddr, ecWdata} = '0;
    repeat (20) @(negedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_out;
    t_in;
    t_flags;
    t_ch2;
    t_b2b;
    t_fifo;
    end_of_test;
  end
endmodule : tb_top
bind pmhc_channel pmhc_props chk (.core_clk, .rst_n, .hostSel, .hostAddr2, .hostRd, .hostRdata,
  .hostReady, .ecAddr, .ecWr, .ecRd, .ecWdata, .ecRdata, .sciOut, .smiOut);
`default_nettype wire
